// File: logic/rss_event_flags.sv
// sticky event flags with enable, clear and one level interrupt
`timescale 1ns/10ps
`default_nettype none
`include "rss_params.svh"

module rss_event_flags (
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire logic                  syncClear,
	input  wire logic [`RSS_EVT_W-1:0] eventIn,
	input  wire logic [`RSS_EVT_W-1:0] clearMask,
	input  wire logic                  enableWrite,
	input  wire logic [`RSS_EVT_W-1:0] enableData,
	output logic      [`RSS_EVT_W-1:0] status,
	output logic      [`RSS_EVT_W-1:0] enable,
	output logic                       irq
);

	rss_pkg::rss_flags_t state_q;
	rss_pkg::rss_flags_t state_d;

	always_comb begin
		state_d = state_q;
		// set wins over a clear in the same cycle
		state_d.status = (state_q.status & ~clearMask) | eventIn;
		if (enableWrite) begin
			state_d.enable = enableData;
		end
		if (syncClear) begin
			state_d.status = '0;
			state_d.enable = '0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign status = state_q.status;
	assign enable = state_q.enable;
	assign irq    = |(state_q.status & state_q.enable);

endmodule
`default_nettype wire

// File: logic/rss_params.svh
// offsets, field positions, reset values of the reset supervisor
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

`define RSS_OFS_CLK_MON_MODE   8'h00
`define RSS_OFS_RESET_CAUSE    8'h04
`define RSS_OFS_DET_CONTROL    8'h08
`define RSS_OFS_DET_LEVEL      8'h0C
`define RSS_OFS_IRQ_STATUS     8'h10
`define RSS_OFS_IRQ_CLEAR      8'h14
`define RSS_OFS_IRQ_ENABLE     8'h18

`define RSS_BIT_CM_ENABLE      0
`define RSS_BIT_CAUSE_LVD      0
`define RSS_BIT_CAUSE_CM       1
`define RSS_BIT_CAUSE_WDT      4
`define RSS_BIT_DET_FLAG       0
`define RSS_BIT_DET_MODE       1
`define RSS_BIT_DET_ON         7
`define RSS_LEVEL_W            4

`define RSS_EVT_W              3
`define RSS_EVT_CM_RESET       0
`define RSS_EVT_LVD_RESET      1
`define RSS_EVT_LVD_IRQ        2

`define RSS_RST_CAUSE          8'h00
`define RSS_RST_LEVEL          4'h0

`endif

// File: logic/rss_pkg.sv
// types of the reset supervisor
package rss_pkg;

	typedef struct packed {
		logic        cmEnable;
		logic [7:0]  cause;
		logic        voltage_detector_on;
		logic        lviMode;
		logic [3:0]  level;
		logic        detPrev;
		logic        ack;
		logic [31:0] rdata;
		logic        intReset;
	} rss_state_t;

	typedef struct packed {
		logic [2:0] status;
		logic [2:0] enable;
	} rss_flags_t;

endpackage

// File: logic/rss_reset_supervisor.sv
// reset-source supervisor with avalon-mm register slave
`timescale 1ns/10ps
`default_nettype none
`include "rss_params.svh"

module rss_reset_supervisor (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        powerOnClearReq,
	input  wire logic        clockMonitorFail,
	input  wire logic        watchdogResetReq,
	input  wire logic        lowVoltageSense,
	output logic             detectorEnable,
	output logic      [3:0]  detectLevel,
	output logic             internalResetOut,
	output logic             irq
);

	rss_pkg::rss_state_t st_q;
	rss_pkg::rss_state_t st_d;

	logic                  req;
	logic                  capture;
	logic                  commit;
	logic                  wrLow;
	logic                  lviEvt;
	logic                  cmEvt;
	logic                  lviRst;
	logic [`RSS_EVT_W-1:0] events;
	logic [`RSS_EVT_W-1:0] irqStatus;
	logic [`RSS_EVT_W-1:0] irqEnable;
	logic [`RSS_EVT_W-1:0] irqClear;
	logic                  irqEnWrite;
	logic [31:0]           rdMux;
	logic [7:0]            causeRead;
	logic                  selClkMon;
	logic                  selCause;
	logic                  selDetCtl;
	logic                  selLevel;
	logic                  selStatus;
	logic                  selClear;
	logic                  selEnable;

	// one wait state: data is registered before the bus may sample it
	assign req     = avs_read | avs_write;
	assign capture = req & ~st_q.ack;
	assign commit  = req & st_q.ack;
	assign wrLow   = commit & avs_write & avs_byteenable[0];
	assign avs_waitrequest = req & ~st_q.ack;

	// one decode shared by read and write paths, so both agree on holes
	always_comb begin
		selClkMon = 1'b0;
		selCause  = 1'b0;
		selDetCtl = 1'b0;
		selLevel  = 1'b0;
		selStatus = 1'b0;
		selClear  = 1'b0;
		selEnable = 1'b0;
		if (avs_address == `RSS_OFS_CLK_MON_MODE) begin
			selClkMon = 1'b1;
		end else if (avs_address == `RSS_OFS_RESET_CAUSE) begin
			selCause = 1'b1;
		end else if (avs_address == `RSS_OFS_DET_CONTROL) begin
			selDetCtl = 1'b1;
		end else if (avs_address == `RSS_OFS_DET_LEVEL) begin
			selLevel = 1'b1;
		end else if (avs_address == `RSS_OFS_IRQ_STATUS) begin
			selStatus = 1'b1;
		end else if (avs_address == `RSS_OFS_IRQ_CLEAR) begin
			selClear = 1'b1;
		end else if (avs_address == `RSS_OFS_IRQ_ENABLE) begin
			selEnable = 1'b1;
		end
	end

	assign lviEvt = st_q.voltage_detector_on & lowVoltageSense & ~st_q.detPrev;
	assign cmEvt  = st_q.cmEnable & clockMonitorFail;
	assign lviRst = lviEvt & st_q.lviMode;

	always_comb begin
		events = '0;
		events[`RSS_EVT_CM_RESET]  = cmEvt;
		events[`RSS_EVT_LVD_RESET] = lviRst;
		events[`RSS_EVT_LVD_IRQ]   = lviEvt & ~st_q.lviMode;
	end

	assign irqEnWrite = wrLow && selEnable;

	always_comb begin
		irqClear = '0;
		if (wrLow && selClear) begin
			irqClear = avs_writedata[`RSS_EVT_W-1:0];
		end
	end

	// read mux; reserved bits read zero
	always_comb begin
		rdMux = 32'h0000_0000;
		if (selClkMon) begin
			rdMux[`RSS_BIT_CM_ENABLE] = st_q.cmEnable;
		end else if (selCause) begin
			rdMux[7:0] = st_q.cause;
		end else if (selDetCtl) begin
			rdMux[`RSS_BIT_DET_ON]   = st_q.voltage_detector_on;
			rdMux[`RSS_BIT_DET_MODE] = st_q.lviMode;
			rdMux[`RSS_BIT_DET_FLAG] = st_q.detPrev;
		end else if (selLevel) begin
			rdMux[`RSS_LEVEL_W-1:0] = st_q.level;
		end else if (selStatus) begin
			rdMux[`RSS_EVT_W-1:0] = irqStatus;
		end else if (selEnable) begin
			rdMux[`RSS_EVT_W-1:0] = irqEnable;
		end else begin
			rdMux = 32'h0000_0000;
		end
	end

	// a read empties the cause register, so bit reads would lose flags
	always_comb begin
		causeRead = st_q.cause;
		if (capture && avs_read && selCause) begin
			causeRead = `RSS_RST_CAUSE;
		end
	end

	always_comb begin
		st_d          = st_q;
		st_d.intReset = 1'b0;
		st_d.ack      = capture;
		st_d.cause    = causeRead;
		if (capture) begin
			st_d.rdata = avs_read ? rdMux : 32'h0000_0000;
		end
		if (wrLow) begin
			if (selClkMon) begin
				st_d.cmEnable = st_q.cmEnable | avs_writedata[`RSS_BIT_CM_ENABLE];
			end else if (selDetCtl) begin
				st_d.voltage_detector_on   = avs_writedata[`RSS_BIT_DET_ON];
				st_d.lviMode = avs_writedata[`RSS_BIT_DET_MODE];
			end else if (selLevel) begin
				st_d.level = avs_writedata[`RSS_LEVEL_W-1:0];
			end
		end
		st_d.detPrev = st_q.voltage_detector_on & lowVoltageSense;
		if (!st_d.voltage_detector_on) begin
			st_d.detPrev = 1'b0;
		end
		// set of a cause wins over the read-clear above
		if (cmEvt || lviRst || watchdogResetReq) begin
			st_d.cmEnable = 1'b0;
			st_d.intReset = 1'b1;
			st_d.voltage_detector_on   = st_d.voltage_detector_on;
			st_d.lviMode = st_d.lviMode;
			st_d.level   = st_d.level;
		end
		if (cmEvt) begin
			st_d.cause[`RSS_BIT_CAUSE_CM] = 1'b1;
		end
		if (lviRst) begin
			st_d.cause[`RSS_BIT_CAUSE_LVD] = 1'b1;
		end
		if (watchdogResetReq) begin
			st_d.cause[`RSS_BIT_CAUSE_WDT] = 1'b1;
		end
		if (powerOnClearReq) begin
			st_d.cause    = `RSS_RST_CAUSE;
			st_d.cmEnable = 1'b0;
			st_d.voltage_detector_on    = 1'b0;
			st_d.lviMode  = 1'b0;
			st_d.level    = `RSS_RST_LEVEL;
			st_d.detPrev  = 1'b0;
			st_d.intReset = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_q       <= '0;
			st_q.cause <= `RSS_RST_CAUSE;
			st_q.level <= `RSS_RST_LEVEL;
		end else begin
			st_q <= st_d;
		end
	end

	rss_event_flags u_flags (
		.core_clk    (core_clk),
		.resetn      (resetn),
		.syncClear   (powerOnClearReq),
		.eventIn     (events),
		.clearMask   (irqClear),
		.enableWrite (irqEnWrite),
		.enableData  (avs_writedata[`RSS_EVT_W-1:0]),
		.status      (irqStatus),
		.enable      (irqEnable),
		.irq         (irq)
	);

	assign avs_readdata     = st_q.rdata;
	assign detectorEnable   = st_q.voltage_detector_on;
	assign detectLevel      = st_q.level;
	assign internalResetOut = st_q.intReset;

endmodule
`default_nettype wire

// File: verif/rss_reset_monitor.sv
// port-level assertions of the reset supervisor
`timescale 1ns/10ps
`default_nettype none
`include "rss_params.svh"

module rss_reset_monitor (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        powerOnClearReq,
	input wire logic        clockMonitorFail,
	input wire logic        watchdogResetReq,
	input wire logic        lowVoltageSense,
	input wire logic        detectorEnable,
	input wire logic [3:0]  detectLevel,
	input wire logic        internalResetOut,
	input wire logic        irq
);
	logic wrAcc;
	logic cmOn_q;
	logic cmOn_d;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	assign wrAcc = avs_write && !avs_waitrequest && avs_byteenable[0];

	// cleared on any sense level too: only a set model is trusted
	always_comb begin
		cmOn_d = cmOn_q;
		if (wrAcc && avs_address == `RSS_OFS_CLK_MON_MODE && avs_writedata[0]) cmOn_d = 1'b1;
		if (powerOnClearReq || watchdogResetReq || clockMonitorFail || lowVoltageSense) cmOn_d = 1'b0;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) cmOn_q <= 1'b0;
		else cmOn_q <= cmOn_d;
	end

	sequence s_ctlWrite;
		wrAcc && avs_address == `RSS_OFS_DET_CONTROL;
	endsequence

	a_cm_set_only: assert property (avs_read && !avs_waitrequest &&
		avs_address == `RSS_OFS_CLK_MON_MODE && $past(cmOn_q) |-> avs_readdata[0])
		else $error("clock monitor enable lost without reset");
	a_cm_fail_reset: assert property (clockMonitorFail && cmOn_q && !powerOnClearReq
		|=> internalResetOut) else $error("clock monitor fail gave no reset");
	a_poc_wipes_all: assert property (powerOnClearReq
		|=> !detectorEnable && detectLevel == 4'h0 && !irq) else $error("power-on clear left state");
	a_det_stop: assert property (s_ctlWrite ##0 !avs_writedata[7] |=> !detectorEnable)
		else $error("detector still on after stop write");
	a_det_survives: assert property ((watchdogResetReq || lowVoltageSense) &&
		!powerOnClearReq && !wrAcc
		|=> $stable(detectorEnable) && $stable(detectLevel)) else $error("detector state reset");
endmodule

bind rss_reset_supervisor rss_reset_monitor u_rss_reset_monitor (.*);
`default_nettype wire

// File: verif/rss_reset_supervisor_tb_top.sv
// self-checking bench of the reset supervisor
`timescale 1ns/10ps
`default_nettype none
`include "rss_params.svh"

module rss_reset_supervisor_tb_top;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        powerOnClearReq = 1'b0;
	logic        clockMonitorFail = 1'b0;
	logic        watchdogResetReq = 1'b0;
	logic        lowVoltageSense = 1'b0;
	logic        detectorEnable;
	logic [3:0]  detectLevel;
	logic        internalResetOut;
	logic        irq;
	logic [31:0] q;
	logic [7:0]  d;
	logic [3:0]  lvl;
	logic        cmExp;
	logic        rs;
	int          bad_count = 0;
	int          cmp_count = 0;

	always #50 core_clk = ~core_clk;

	rss_reset_supervisor u_rss_reset_supervisor (.*);

	task automatic test_done;
		$display("compares %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	// expected cause word from the sources that fired since the last read
	function automatic logic [31:0] causeWord(input logic lvd, input logic cm, input logic wdt);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`RSS_BIT_CAUSE_LVD] = lvd;
		w[`RSS_BIT_CAUSE_CM]  = cm;
		w[`RSS_BIT_CAUSE_WDT] = wdt;
		return w;
	endfunction

	// one bus cycle; ends an edge after release so the next may start
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
		int n;
		n = 0;
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= 32'(wd);
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest && n < 20);
		if (avs_waitrequest) begin
			bad_count++;
			test_done();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask

	task automatic evt(input logic [3:0] m);
		{lowVoltageSense, watchdogResetReq, clockMonitorFail, powerOnClearReq} <= m;
		@(posedge core_clk);
		{lowVoltageSense, watchdogResetReq, clockMonitorFail, powerOnClearReq} <= 4'h0;
		// reset pulse taken mid-cycle, away from the edges that move it
		@(negedge core_clk);
		rs = internalResetOut;
		@(posedge core_clk);
	endtask

	initial begin
		void'($urandom(40));
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		// random writes never clear the enable
		cmExp = 1'b0;
		for (int i = 0; i < 6; i++) begin
			d = (i == 1) ? 8'h01 : (i == 5) ? 8'hFE : 8'($urandom);
			cmExp = cmExp | d[0];
			bus(1'b1, `RSS_OFS_CLK_MON_MODE, d);
			rdc(`RSS_OFS_CLK_MON_MODE, 32'(cmExp));
		end
		// monitor reset, then irq
		evt(4'h2);
		chk(32'(rs), 32'h0000_0001);
		rdc(`RSS_OFS_CLK_MON_MODE, 32'h0000_0000);
		rdc(`RSS_OFS_RESET_CAUSE, causeWord(1'b0, 1'b1, 1'b0));
		rdc(`RSS_OFS_IRQ_STATUS, 32'h0000_0001);
		bus(1'b1, `RSS_OFS_IRQ_ENABLE, 8'h07);
		chk(32'(irq), 32'h0000_0001);
		bus(1'b1, `RSS_OFS_IRQ_CLEAR, 8'h01);
		chk(32'(irq), 32'h0000_0000);
		rdc(8'hFC, 32'h0000_0000);
		// detector survives internal resets
		lvl = 4'($urandom);
		bus(1'b1, `RSS_OFS_DET_LEVEL, {4'h0, lvl});
		rdc(`RSS_OFS_DET_LEVEL, 32'(lvl));
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, `RSS_OFS_DET_CONTROL, 8'h82);
			evt(4'h8);
			chk(32'(rs), 32'h0000_0001);
			rdc(`RSS_OFS_RESET_CAUSE, causeWord(1'b1, 1'b0, 1'b0));
			evt(4'h4);
			rdc(`RSS_OFS_RESET_CAUSE, causeWord(1'b0, 1'b0, 1'b1));
			chk(32'(detectorEnable), 32'h0000_0001);
			chk(32'(detectLevel), 32'(lvl));
			bus(1'b1, `RSS_OFS_DET_CONTROL, (k == 0) ? 8'h00 : 8'h02);
			chk(32'(detectorEnable), 32'h0000_0000);
		end
		// interrupt mode gives no reset; monitor fail ignored while disabled
		bus(1'b1, `RSS_OFS_DET_CONTROL, 8'h80);
		evt(4'hA);
		chk(32'(rs), 32'h0000_0000);
		rdc(`RSS_OFS_IRQ_STATUS, 32'h0000_0006);
		rdc(`RSS_OFS_RESET_CAUSE, 32'h0000_0000);
		// power-on clear wipes
		evt(4'h4);
		bus(1'b1, `RSS_OFS_CLK_MON_MODE, 8'h01);
		bus(1'b1, `RSS_OFS_DET_CONTROL, 8'h80);
		evt(4'h1);
		chk(32'(rs), 32'h0000_0001);
		rdc(`RSS_OFS_RESET_CAUSE, 32'h0000_0000);
		rdc(`RSS_OFS_CLK_MON_MODE, 32'h0000_0000);
		chk(32'(detectorEnable), 32'h0000_0000);
		// external reset pin in mid-run also clears the enable
		bus(1'b1, `RSS_OFS_CLK_MON_MODE, 8'h01);
		rdc(`RSS_OFS_CLK_MON_MODE, 32'h0000_0001);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rdc(`RSS_OFS_CLK_MON_MODE, 32'h0000_0000);
		test_done();
	end
endmodule
`default_nettype wire
